/* File: hdl/mmp_pkg.sv */
package mmp_pkg;
    // system clock and management clock rates
    localparam int SYS_CLK_HZ   = 40_000_000;
    localparam int MDC_HZ       = 2_500_000;
    localparam int MDC_HALF_CYC = SYS_CLK_HZ / (2 * MDC_HZ);
    localparam logic [3:0] MDC_HALF_LAST = 4'(MDC_HALF_CYC - 1);

    // management frame layout, bit index 0 goes out first
    localparam logic [31:0] MDIO_PREAMBLE   = 32'hFFFF_FFFF;
    localparam logic [1:0]  MDIO_START      = 2'h1;
    localparam logic [1:0]  MDIO_OP_WRITE   = 2'h1;
    localparam logic [1:0]  MDIO_OP_READ    = 2'h2;
    localparam logic [1:0]  MDIO_TA_WRITE   = 2'h2;
    localparam logic [1:0]  MDIO_TA_READ    = 2'h3;
    localparam logic [5:0]  MDIO_TA_PREV    = 6'h2D;
    localparam logic [5:0]  MDIO_RD_FIRST   = 6'h30;
    localparam logic [5:0]  MDIO_FRAME_LAST = 6'h3F;
    localparam logic [15:0] MDIO_NO_DATA    = 16'h0000;

    // link symbol layout
    localparam logic [1:0] MII_BYTE_LAST  = 2'h1;
    localparam logic [1:0] RMII_BYTE_LAST = 2'h3;
    localparam logic [2:0] WORD_BYTES     = 3'h4;

    typedef enum logic [1:0] {
        MMP_M_IDLE  = 2'b00,
        MMP_M_SHIFT = 2'b01,
        MMP_M_DONE  = 2'b11
    } mmp_mgmt_state_t;
endpackage

/* File: hdl/mmp_mgmt_if.sv */
`timescale 1ns/1ps
interface mmp_mgmt_if;
    logic        start;
    logic        rd;
    logic [4:0]  phy;
    logic [4:0]  regad;
    logic [15:0] wdata;
    logic        busy;
    logic        done;
    logic [15:0] rdata;

    modport ctrl   (output start, rd, phy, regad, wdata, input busy, done, rdata);
    modport engine (input start, rd, phy, regad, wdata, output busy, done, rdata);
endinterface

/* File: hdl/mmp_mdio.sv */
`timescale 1ns/1ps
module mmp_mdio (
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   reset_in,
    // request side
    mmp_mgmt_if.engine  m,
    // management pins
    output logic        mdc_out,
    input  wire logic   mdio_in,
    output logic        mdio_out,
    output logic        mdio_oe_out
);
    mmp_pkg::mmp_mgmt_state_t st_reg, st_next;
    logic [3:0]  ph_reg,    ph_next;
    logic        mdc_reg,   mdc_next;
    logic [5:0]  bit_reg,   bit_next;
    logic [63:0] sh_reg,    sh_next;
    logic [15:0] rd_reg,    rd_next;
    logic        rdop_reg,  rdop_next;
    logic        oe_reg,    oe_next;
    logic        mdio_s1, mdio_s2;

    ////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_next   = st_reg;
        ph_next   = ph_reg;
        mdc_next  = mdc_reg;
        bit_next  = bit_reg;
        sh_next   = sh_reg;
        rd_next   = rd_reg;
        rdop_next = rdop_reg;
        oe_next   = oe_reg;
        case (st_reg)
            mmp_pkg::MMP_M_IDLE:
            begin
                mdc_next = 1'b0;
                oe_next  = 1'b0;
                if (m.start)
                begin
                    st_next   = mmp_pkg::MMP_M_SHIFT;
                    ph_next   = '0;
                    bit_next  = '0;
                    rdop_next = m.rd;
                    oe_next   = 1'b1;
                    sh_next   = {mmp_pkg::MDIO_PREAMBLE, mmp_pkg::MDIO_START,
                                 m.rd ? mmp_pkg::MDIO_OP_READ : mmp_pkg::MDIO_OP_WRITE,
                                 m.phy, m.regad,
                                 m.rd ? mmp_pkg::MDIO_TA_READ : mmp_pkg::MDIO_TA_WRITE,
                                 m.rd ? mmp_pkg::MDIO_NO_DATA : m.wdata};
                end
            end
            mmp_pkg::MMP_M_SHIFT:
            begin
                if (ph_reg == mmp_pkg::MDC_HALF_LAST)
                begin
                    ph_next  = '0;
                    mdc_next = !mdc_reg;
                    // read data is caught just before the rising edge
                    if (!mdc_reg && rdop_reg && bit_reg >= mmp_pkg::MDIO_RD_FIRST)
                        rd_next = {rd_reg[14:0], mdio_s2};
                    // output moves only on the falling edge
                    if (mdc_reg)
                    begin
                        if (bit_reg == mmp_pkg::MDIO_FRAME_LAST)
                        begin
                            st_next = mmp_pkg::MMP_M_DONE;
                            oe_next = 1'b0;
                        end
                        else
                        begin
                            bit_next = bit_reg + 6'h01;
                            sh_next  = {sh_reg[62:0], 1'b0};
                            if (rdop_reg && bit_reg == mmp_pkg::MDIO_TA_PREV)
                                oe_next = 1'b0;
                        end
                    end
                end
                else
                    ph_next = ph_reg + 4'h1;
            end
            mmp_pkg::MMP_M_DONE:
                st_next = mmp_pkg::MMP_M_IDLE;
            default:
                st_next = mmp_pkg::MMP_M_IDLE;
        endcase
        if (reset_in)
        begin
            st_next   = mmp_pkg::MMP_M_IDLE;
            ph_next   = '0;
            mdc_next  = 1'b0;
            bit_next  = '0;
            sh_next   = '0;
            rd_next   = '0;
            rdop_next = 1'b0;
            oe_next   = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        st_reg   <= st_next;
        ph_reg   <= ph_next;
        mdc_reg  <= mdc_next;
        bit_reg  <= bit_next;
        sh_reg   <= sh_next;
        rd_reg   <= rd_next;
        rdop_reg <= rdop_next;
        oe_reg   <= oe_next;
        mdio_s1  <= mdio_in;
        mdio_s2  <= mdio_s1;
    end

    assign m.busy      = st_reg != mmp_pkg::MMP_M_IDLE;
    assign m.done      = st_reg == mmp_pkg::MMP_M_DONE;
    assign m.rdata     = rd_reg;
    assign mdc_out     = mdc_reg;
    assign mdio_out    = sh_reg[63];
    assign mdio_oe_out = oe_reg;

    ////////////////////////////////////////////////////////////////
    mdio_edge_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $rose(mdc_out) |-> $stable(mdio_out) && $stable(mdio_oe_out))
        else $error("management data moved at clock rise");
    mdc_high_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $rose(mdc_out) |-> mdc_out[*8] ##1 !mdc_out)
        else $error("management clock high phase wrong");
    mdio_release_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (st_reg == mmp_pkg::MMP_M_SHIFT && rdop_reg && bit_reg > mmp_pkg::MDIO_TA_PREV)
        |-> !mdio_oe_out)
        else $error("data line driven during read reply");
endmodule

/* File: hdl/mmp_port.sv */
`timescale 1ns/1ps
module mmp_port (
    // system clock, reset, mode strap
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    input  wire logic        mode_rmii_in,
    // link clocks from the phy
    input  wire logic        tx_nibble_clock_in,
    input  wire logic        rx_nibble_clock_in,
    // management requests
    input  wire logic        mgmt_start_in,
    input  wire logic        mgmt_read_in,
    input  wire logic [4:0]  mgmt_phy_in,
    input  wire logic [4:0]  mgmt_reg_in,
    input  wire logic [15:0] mgmt_wdata_in,
    output logic             mgmt_busy_out,
    output logic             mgmt_done_out,
    output logic [15:0]      mgmt_rdata_out,
    // management pins
    output logic             mgmt_clock_port_b_out,
    input  wire logic        mgmt_data_io_port_b_in,
    output logic             mgmt_data_io_port_b_out,
    output logic             mgmt_data_io_port_b_oe_out,
    // transmit words
    input  wire logic        tx_valid_in,
    input  wire logic [31:0] tx_word_in,
    input  wire logic [2:0]  tx_bytes_in,
    input  wire logic        tx_last_in,
    output logic             tx_ready_out,
    // transmit pins
    output logic [3:0]       tx_nibble_bus_out,
    output logic             tx_enable_out,
    // receive pins
    input  wire logic [3:0]  rx_nibble_bus_in,
    input  wire logic        rx_valid_in,
    input  wire logic        rx_error_in,
    input  wire logic        collision_in,
    input  wire logic        carrier_sense_in,
    // receive words and line status
    output logic             rx_word_valid_out,
    output logic [31:0]      rx_word_out,
    output logic [2:0]       rx_bytes_out,
    output logic             rx_last_out,
    output logic             rx_crc_error_out,
    output logic             collision_out,
    output logic             carrier_out
);
    mmp_mgmt_if mgmt ();
    logic tx_link_clk;

    ////////////////////////////////////////////////////////////////
    // system domain: mode strap, line status, management
    logic mode_reg, mode_next;
    logic mode_s1, mode_s2;
    logic col_s1, col_s2, crs_s1, crs_s2;

    // strap is only followed by mode_reg while reset is held; the link sides sync mode_rmii_in at all times
    always_comb
        mode_next = reset_in ? mode_s2 : mode_reg;

    always_ff @(posedge clk_in)
    begin
        mode_reg <= mode_next;
        mode_s1  <= mode_rmii_in;
        mode_s2  <= mode_s1;
        col_s1   <= collision_in;
        col_s2   <= col_s1;
        crs_s1   <= carrier_sense_in;
        crs_s2   <= crs_s1;
    end

    assign collision_out = col_s2 && !mode_reg;
    assign carrier_out   = crs_s2 && !mode_reg;

    assign mgmt.start     = mgmt_start_in;
    assign mgmt.rd        = mgmt_read_in;
    assign mgmt.phy       = mgmt_phy_in;
    assign mgmt.regad     = mgmt_reg_in;
    assign mgmt.wdata     = mgmt_wdata_in;
    assign mgmt_busy_out  = mgmt.busy;
    assign mgmt_done_out  = mgmt.done;
    assign mgmt_rdata_out = mgmt.rdata;

    mmp_mdio u_mdio (
        .clk_in      (clk_in),
        .reset_in    (reset_in),
        .m           (mgmt),
        .mdc_out     (mgmt_clock_port_b_out),
        .mdio_in     (mgmt_data_io_port_b_in),
        .mdio_out    (mgmt_data_io_port_b_out),
        .mdio_oe_out (mgmt_data_io_port_b_oe_out)
    );

    ////////////////////////////////////////////////////////////////
    // transmit, system side: word held until the link acknowledges
    logic        treq_reg, treq_next;
    logic [31:0] thold_reg, thold_next;
    logic [2:0]  tbytes_reg, tbytes_next;
    logic        tlast_reg, tlast_next;
    logic        tack_s1, tack_s2;

    assign tx_ready_out = treq_reg == tack_s2;

    always_comb
    begin
        treq_next   = treq_reg;
        thold_next  = thold_reg;
        tbytes_next = tbytes_reg;
        tlast_next  = tlast_reg;
        if (tx_valid_in && tx_ready_out)
        begin
            treq_next   = !treq_reg;
            thold_next  = tx_word_in;
            tbytes_next = tx_bytes_in;
            tlast_next  = tx_last_in;
        end
        if (reset_in)
        begin
            treq_next   = 1'b0;
            thold_next  = '0;
            tbytes_next = '0;
            tlast_next  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // transmit, link side; rmii times transmit off the reference clock
    // clock choice follows mode_rmii_in directly, not the strap latched in reset, so it moves whenever that pin does
    assign tx_link_clk = mode_rmii_in ? rx_nibble_clock_in : tx_nibble_clock_in;

    logic        trst_s1, trst_s2, tmode_s1, tmode_s2, treq_s1, treq_s2;
    logic        tack_reg, tack_next;
    logic [31:0] tsh_reg, tsh_next;
    logic [4:0]  tsym_reg, tsym_next;
    logic        tfin_reg, tfin_next;
    logic        ten_reg, ten_next;
    logic [3:0]  tbus_reg, tbus_next;
    logic        tavail, tload;

    assign tavail = treq_s2 != tack_reg;

    always_comb
    begin
        tsh_next  = tsh_reg;
        tsym_next = tsym_reg;
        tfin_next = tfin_reg;
        tack_next = tack_reg;
        ten_next  = 1'b0;
        tbus_next = '0;
        tload     = 1'b0;
        if (tsym_reg != 5'h00)
        begin
            ten_next  = 1'b1;
            tbus_next = tmode_s2 ? {2'b00, tsh_reg[1:0]} : tsh_reg[3:0];
            tsh_next  = tmode_s2 ? {2'b00, tsh_reg[31:2]} : {4'h0, tsh_reg[31:4]};
            tsym_next = tsym_reg - 5'h01;
            // next word is taken with the last symbol so no gap appears
            tload     = tsym_reg == 5'h01 && !tfin_reg && tavail;
        end
        else
            tload = tavail && !ten_reg;
        if (tload)
        begin
            tsh_next  = thold_reg;
            tsym_next = tmode_s2 ? {tbytes_reg, 2'b00} : {1'b0, tbytes_reg, 1'b0};
            tfin_next = tlast_reg;
            tack_next = !tack_reg;
        end
        if (trst_s2)
        begin
            tsh_next  = '0;
            tsym_next = '0;
            tfin_next = 1'b0;
            tack_next = 1'b0;
            ten_next  = 1'b0;
            tbus_next = '0;
        end
    end

    always_ff @(posedge tx_link_clk)
    begin
        trst_s1  <= reset_in;
        trst_s2  <= trst_s1;
        tmode_s1 <= mode_rmii_in;
        tmode_s2 <= tmode_s1;
        treq_s1  <= treq_reg;
        treq_s2  <= treq_s1;
        tack_reg <= tack_next;
        tsh_reg  <= tsh_next;
        tsym_reg <= tsym_next;
        tfin_reg <= tfin_next;
        ten_reg  <= ten_next;
        tbus_reg <= tbus_next;
    end

    assign tx_nibble_bus_out = tbus_reg;
    assign tx_enable_out     = ten_reg;

    ////////////////////////////////////////////////////////////////
    // receive, link side: bytes packed into words, two banks
    logic        rrst_s1, rrst_s2, rmode_s1, rmode_s2;
    logic        rdv_reg, rdv_next;
    logic [7:0]  rsh_reg, rsh_next;
    logic [1:0]  rcnt_reg, rcnt_next;
    logic [31:0] rasm_reg, rasm_next;
    logic [2:0]  racnt_reg, racnt_next;
    logic        rerr_reg, rerr_next;
    logic        rtog_reg, rtog_next;
    logic [31:0] bw_reg [2], bw_next [2];
    logic [2:0]  bb_reg [2], bb_next [2];
    logic        bl_reg [2], bl_next [2];
    logic        be_reg [2], be_next [2];
    logic        rbyte;

    always_comb
    begin
        rsh_next   = rsh_reg;
        rcnt_next  = rcnt_reg;
        rasm_next  = rasm_reg;
        racnt_next = racnt_reg;
        rerr_next  = rerr_reg;
        rtog_next  = rtog_reg;
        bw_next    = bw_reg;
        bb_next    = bb_reg;
        bl_next    = bl_reg;
        be_next    = be_reg;
        rdv_next   = rx_valid_in;
        rbyte      = 1'b0;
        // data lines are looked at only while valid is high
        if (rx_valid_in)
        begin
            rsh_next  = rmode_s2 ? {rx_nibble_bus_in[1:0], rsh_reg[7:2]}
                                 : {rx_nibble_bus_in, rsh_reg[7:4]};
            rbyte     = rcnt_reg == (rmode_s2 ? mmp_pkg::RMII_BYTE_LAST
                                              : mmp_pkg::MII_BYTE_LAST);
            rcnt_next = rbyte ? 2'h0 : rcnt_reg + 2'h1;
            rerr_next = rerr_reg || rx_error_in;
            if (rbyte)
            begin
                // a full word waits for the next byte so the end mark rides on it
                if (racnt_reg == mmp_pkg::WORD_BYTES)
                begin
                    bw_next[rtog_reg] = rasm_reg;
                    bb_next[rtog_reg] = mmp_pkg::WORD_BYTES;
                    bl_next[rtog_reg] = 1'b0;
                    be_next[rtog_reg] = 1'b0;
                    rtog_next         = !rtog_reg;
                    rasm_next         = {24'h00_0000, rsh_next};
                    racnt_next        = 3'h1;
                end
                else
                begin
                    rasm_next[8 * racnt_reg[1:0] +: 8] = rsh_next;
                    racnt_next = racnt_reg + 3'h1;
                end
            end
        end
        else if (rdv_reg)
        begin
            // end of frame; a trailing partial byte is dropped
            if (racnt_reg != 3'h0)
            begin
                bw_next[rtog_reg] = rasm_reg;
                bb_next[rtog_reg] = racnt_reg;
                bl_next[rtog_reg] = 1'b1;
                be_next[rtog_reg] = rerr_reg;
                rtog_next         = !rtog_reg;
            end
            rasm_next  = '0;
            racnt_next = '0;
            rcnt_next  = '0;
            rerr_next  = 1'b0;
        end
        if (rrst_s2)
        begin
            rdv_next   = 1'b0;
            rsh_next   = '0;
            rcnt_next  = '0;
            rasm_next  = '0;
            racnt_next = '0;
            rerr_next  = 1'b0;
            rtog_next  = 1'b0;
        end
    end

    always_ff @(posedge rx_nibble_clock_in)
    begin
        rrst_s1   <= reset_in;
        rrst_s2   <= rrst_s1;
        rmode_s1  <= mode_rmii_in;
        rmode_s2  <= rmode_s1;
        rdv_reg   <= rdv_next;
        rsh_reg   <= rsh_next;
        rcnt_reg  <= rcnt_next;
        rasm_reg  <= rasm_next;
        racnt_reg <= racnt_next;
        rerr_reg  <= rerr_next;
        rtog_reg  <= rtog_next;
        bw_reg    <= bw_next;
        bb_reg    <= bb_next;
        bl_reg    <= bl_next;
        be_reg    <= be_next;
    end

    ////////////////////////////////////////////////////////////////
    // receive, system side: the bank last written is the old toggle
    logic        rt_s1, rt_s2, rt_s3;
    logic        rv_reg, rv_next;
    logic [31:0] rw_reg, rw_next;
    logic [2:0]  rb_reg, rb_next;
    logic        rl_reg, rl_next;
    logic        re_reg, re_next;

    always_comb
    begin
        rv_next = rt_s2 != rt_s3;
        rw_next = rw_reg;
        rb_next = rb_reg;
        rl_next = rl_reg;
        re_next = re_reg;
        if (rv_next)
        begin
            rw_next = bw_reg[rt_s3];
            rb_next = bb_reg[rt_s3];
            rl_next = bl_reg[rt_s3];
            re_next = be_reg[rt_s3];
        end
        if (reset_in)
        begin
            rv_next = 1'b0;
            rw_next = '0;
            rb_next = '0;
            rl_next = 1'b0;
            re_next = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        treq_reg   <= treq_next;
        thold_reg  <= thold_next;
        tbytes_reg <= tbytes_next;
        tlast_reg  <= tlast_next;
        tack_s1    <= tack_reg;
        tack_s2    <= tack_s1;
        rt_s1      <= rtog_reg;
        rt_s2      <= rt_s1;
        rt_s3      <= rt_s2;
        rv_reg     <= rv_next;
        rw_reg     <= rw_next;
        rb_reg     <= rb_next;
        rl_reg     <= rl_next;
        re_reg     <= re_next;
    end

    assign rx_word_valid_out = rv_reg;
    assign rx_word_out       = rw_reg;
    assign rx_bytes_out      = rb_reg;
    assign rx_last_out       = rl_reg;
    assign rx_crc_error_out  = re_reg;

    ////////////////////////////////////////////////////////////////
    tx_low_pair_a: assert property (
        @(posedge tx_link_clk) disable iff (trst_s2)
        tmode_s2 |-> tbus_reg[3:2] == 2'b00)
        else $error("upper transmit lines used in rmii");
    tx_en_span_a: assert property (
        @(posedge tx_link_clk) disable iff (trst_s2)
        tsym_reg != 5'h00 |=> ten_reg)
        else $error("transmit enable dropped inside frame");
    tx_mii_word_a: assert property (
        @(posedge tx_link_clk) disable iff (trst_s2)
        (tload && !ten_reg && !tmode_s2 && tbytes_reg == 3'h4) |=> ##1 ten_reg[*8])
        else $error("mii word not eight nibbles");
    tx_en_quiet_a: assert property (
        @(posedge tx_link_clk) disable iff (trst_s2)
        !ten_reg |-> tbus_reg == 4'h0)
        else $error("transmit data moved while idle");
    rx_gate_a: assert property (
        @(posedge rx_nibble_clock_in) disable iff (rrst_s2)
        !rx_valid_in |=> $stable(rsh_reg))
        else $error("receive data taken while invalid");
    rx_dibit_a: assert property (
        @(posedge rx_nibble_clock_in) disable iff (rrst_s2)
        (rmode_s2 && rx_valid_in) |=> rsh_reg[7:6] == $past(rx_nibble_bus_in[1:0]))
        else $error("rmii receive lane wrong");
    rx_err_flag_a: assert property (
        @(posedge rx_nibble_clock_in) disable iff (rrst_s2)
        (rx_valid_in && rx_error_in) |=> rerr_reg)
        else $error("receive error not recorded");
    rmii_ignore_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        mode_reg |-> !collision_out && !carrier_out)
        else $error("collision or carrier seen in rmii");
    mode_hold_a: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !reset_in |=> $stable(mode_reg))
        else $error("mode changed outside reset");
endmodule

/* File: sim/mmp_phy_model.sv */
`timescale 1ns/1ps
module mmp_phy_model #(
    parameter logic [15:0] RD_PAT = 16'hA5C3
) (
    // link clock and management wire
    output logic        link_clk_out,
    input  wire logic   mode_rmii_in,
    input  wire logic   mdc_in,
    input  wire logic   mdio_oe_in,
    input  wire logic   mdio_wire_in,
    output logic        mdio_out,
    output logic [63:0] mgmt_cap_out,
    // transmit capture
    input  wire logic [3:0] txd_in,
    input  wire logic   txen_in,
    output logic [31:0] tx_cap_out,
    output logic [7:0]  tx_cnt_out
);
    int k = 18;
    logic [7:0] tx_cnt = 8'h00;
    assign tx_cnt_out = tx_cnt;
    initial
    begin
        link_clk_out = 1'b0;
        #7;
        forever #16 link_clk_out = ~link_clk_out;
    end
    always @(posedge mdc_in)
    begin
        mgmt_cap_out <= {mgmt_cap_out[62:0], mdio_wire_in};
        k <= mdio_oe_in ? 0 : k + 1;
    end
    // turnaround low, then data msb first; released line is pulled up
    assign mdio_out = (mdio_oe_in || k > 17) ? 1'b1 : (k < 2 ? 1'b0 : RD_PAT[17 - k]);
    always @(posedge link_clk_out)
        if (txen_in)
        begin
            tx_cap_out <= mode_rmii_in ? {txd_in[1:0], tx_cap_out[31:2]}
                                       : {txd_in, tx_cap_out[31:4]};
            tx_cnt     <= tx_cnt + 8'h01;
        end
endmodule

/* File: sim/mmp_port_tb.sv */
`timescale 1ns/1ps
module mmp_port_tb;
    localparam logic [15:0] RD_PAT = 16'hA5C3;
    logic clk_in, reset_in, mode_rmii_in, lclk, txclk, phy_mdio, wire_lvl;
    logic mgmt_start_in, mgmt_read_in, mgmt_busy_out, mgmt_done_out, mgmt_clock_port_b_out;
    logic [4:0] mgmt_phy_in, mgmt_reg_in;
    logic [15:0] mgmt_wdata_in, mgmt_rdata_out;
    logic mgmt_data_io_port_b_out, mgmt_data_io_port_b_oe_out, tx_valid_in, tx_last_in;
    logic tx_ready_out, tx_enable_out, rx_valid_in, rx_error_in, collision_in, carrier_sense_in;
    logic rx_word_valid_out, rx_last_out, rx_crc_error_out, collision_out, carrier_out;
    logic [31:0] tx_word_in, rx_word_out, tx_cap;
    logic [2:0] tx_bytes_in, rx_bytes_out;
    logic [3:0] tx_nibble_bus_out, rx_nibble_bus_in;
    logic [63:0] mgmt_cap;
    logic [7:0] tx_cnt;
    int fails, samples_checked;
    assign wire_lvl = mgmt_data_io_port_b_oe_out ? mgmt_data_io_port_b_out : phy_mdio;
    // transmit clock pin only pulled up in rmii
    assign txclk = mode_rmii_in ? 1'b1 : lclk;
    mmp_port u_mmp_port (.clk_in, .reset_in, .mode_rmii_in, .tx_nibble_clock_in(txclk),
        .rx_nibble_clock_in(lclk), .mgmt_start_in, .mgmt_read_in, .mgmt_phy_in, .mgmt_reg_in,
        .mgmt_wdata_in, .mgmt_busy_out, .mgmt_done_out, .mgmt_rdata_out, .mgmt_clock_port_b_out,
        .mgmt_data_io_port_b_in(wire_lvl), .mgmt_data_io_port_b_out, .mgmt_data_io_port_b_oe_out,
        .tx_valid_in, .tx_word_in, .tx_bytes_in, .tx_last_in, .tx_ready_out, .tx_nibble_bus_out,
        .tx_enable_out, .rx_nibble_bus_in, .rx_valid_in, .rx_error_in, .collision_in,
        .carrier_sense_in, .rx_word_valid_out, .rx_word_out, .rx_bytes_out, .rx_last_out,
        .rx_crc_error_out, .collision_out, .carrier_out);
    mmp_phy_model #(.RD_PAT(RD_PAT)) u_mmp_phy_model (.link_clk_out(lclk), .mode_rmii_in,
        .mdc_in(mgmt_clock_port_b_out), .mdio_oe_in(mgmt_data_io_port_b_oe_out),
        .mdio_wire_in(wire_lvl), .mdio_out(phy_mdio), .mgmt_cap_out(mgmt_cap),
        .txd_in(tx_nibble_bus_out), .txen_in(tx_enable_out), .tx_cap_out(tx_cap),
        .tx_cnt_out(tx_cnt));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic flag(input int sel);
        if (sel == 0)
            return mgmt_done_out;
        if (sel == 1)
            return tx_ready_out;
        return rx_word_valid_out;
    endfunction
    task automatic wait_hi(input int sel, input int lim, output int n);
        n = 0;
        while (n < lim && flag(sel) !== 1'b1)
        begin
            @(posedge clk_in);
            n++;
        end
        if (n >= lim)
        begin
            fails++;
            $display("MISMATCH %0t wait timed out", $time);
            report_and_stop();
        end
    endtask
    task automatic do_reset(input logic m);
        @(posedge clk_in);
        reset_in <= 1'b1;
        mode_rmii_in <= m;
        collision_in <= m;
        carrier_sense_in <= m;
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
    task automatic mgmt(input logic rd, input logic [4:0] p, input logic [4:0] r,
                        input logic [15:0] d);
        int n;
        @(posedge clk_in);
        mgmt_start_in <= 1'b1;
        mgmt_read_in <= rd;
        mgmt_phy_in <= p;
        mgmt_reg_in <= r;
        mgmt_wdata_in <= d;
        @(posedge clk_in);
        mgmt_start_in <= 1'b0;
        @(posedge clk_in);
        chk_val(mgmt_busy_out, 1'b1);
        wait_hi(0, 1100, n);
        chk_val(n, 1024);
        if (rd)
            chk_val(mgmt_rdata_out, RD_PAT);
        else
            chk_val(mgmt_cap, {32'hFFFF_FFFF, 2'h1, 2'h1, p, r, 2'h2, d});
        $display("mgmt test done rd=%0d", rd);
    endtask
    task automatic tx_send(input logic [31:0] w, input int n);
        int c0;
        int k;
        c0 = tx_cnt;
        @(posedge clk_in);
        tx_valid_in <= 1'b1;
        tx_word_in <= w;
        tx_bytes_in <= 3'h4;
        tx_last_in <= 1'b1;
        @(posedge clk_in);
        wait_hi(1, 100, k);
        tx_valid_in <= 1'b0;
        repeat (60) @(posedge clk_in);
        chk_val(tx_cnt, 8'(c0 + n));
        chk_val(tx_cap, w);
        $display("tx test done");
    endtask
    // five bytes: the full first word must wait for the fifth
    task automatic rx_frame(input logic [39:0] w, input logic err);
        int i;
        int n;
        n = mode_rmii_in ? 20 : 10;
        for (i = 0; i < n; i++)
        begin
            @(posedge lclk);
            rx_valid_in <= 1'b1;
            rx_error_in <= err && (i == 2 || i == 3);
            rx_nibble_bus_in <= mode_rmii_in ? {2'h3, w[2 * i +: 2]} : w[4 * i +: 4];
        end
        @(posedge lclk);
        rx_valid_in <= 1'b0;
        rx_error_in <= 1'b0;
        wait_hi(2, 50, i);
        chk_val({rx_last_out, rx_bytes_out, rx_word_out}, {1'b0, 3'h4, w[31:0]});
        @(posedge clk_in);
        wait_hi(2, 50, i);
        chk_val({rx_last_out, rx_bytes_out, rx_word_out}, {1'b1, 3'h1, 32'(w[39:32])});
        chk_val(rx_crc_error_out, err);
        $display("rx test done");
    endtask
    task automatic run_mode(input int n);
        mgmt(1'b0, 5'h01, 5'h1E, 16'h3C5A);
        mgmt(1'b1, 5'h1F, 5'h00, 16'h0000);
        tx_send(32'h8421_F00D, n);
        rx_frame(40'h5E_1234_ABCD, n == 8);
        @(posedge clk_in);
        collision_in <= 1'b1;
        carrier_sense_in <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk_val({collision_out, carrier_out}, {n == 8, n == 8});
        collision_in <= mode_rmii_in;
        carrier_sense_in <= mode_rmii_in;
        $display("line status test done");
    endtask
    initial
    begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial
    begin
        {reset_in, mode_rmii_in, mgmt_start_in, mgmt_read_in, tx_valid_in, tx_last_in} = '0;
        {rx_valid_in, rx_error_in, collision_in, carrier_sense_in} = '0;
        {mgmt_phy_in, mgmt_reg_in, mgmt_wdata_in, tx_word_in, tx_bytes_in, rx_nibble_bus_in} = '0;
        fails = 0;
        samples_checked = 0;
        do_reset(1'b0);
        run_mode(8);
        do_reset(1'b1);
        run_mode(16);
        report_and_stop();
    end
endmodule
